// [rtl/dfcs_sequencer.sv]
// data-flash command sequencer: verify, program and sector erase
`timescale 1ns/1ps
module dfcs_sequencer #(
    parameter logic [1:0] DF_BLOCK = 2'h1,
    parameter logic [15:0] DF_FIRST = 16'h0000,
    parameter logic [15:0] DF_LAST = 16'h0FFF,
    parameter int SECTOR_BYTES = 256
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic param_index_wr_in,
    input wire logic [dfcs_pkg::IDX_W-1:0] param_index_val_in,
    input wire logic param_data_wr_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] param_data_in,
    input wire logic cmd_complete_clear_in,
    input wire logic access_error_clear_in,
    input wire logic protect_violation_clear_in,
    input wire logic [2:0] cmd_allowed_in,
    input wire logic prot_en_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] prot_lo_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] prot_hi_in,
    input wire logic arr_ack_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] arr_rdata_in,
    input wire logic arr_err_in,
    input wire logic arr_uncorr_err_in,
    output logic arr_req_out,
    output dfcs_pkg::dfcs_op_t arr_op_out,
    output logic [dfcs_pkg::WORD_W-1:0] arr_addr_out,
    output logic [dfcs_pkg::WORD_W-1:0] arr_wdata_out,
    output logic cmd_complete_flag_out,
    output logic access_error_flag_out,
    output logic protect_violation_flag_out,
    output logic any_error_status_out,
    output logic uncorrectable_error_status_out,
    output logic [dfcs_pkg::IDX_W-1:0] param_index_out
);
    import dfcs_pkg::*;

    localparam logic [WORD_W-1:0] SECTOR_MASK = 16'(SECTOR_BYTES - 1);
    localparam logic [CNT_W-1:0] SECTOR_WORDS = 17'(SECTOR_BYTES / 2);

    logic [WORD_W-1:0] cmd_param_array [NPARAM];
    logic [IDX_W-1:0] param_index_reg;
    dfcs_state_t state_reg, state_next;
    dfcs_op_t op_reg, op_next;
    logic cmd_complete_flag_reg, cmd_complete_flag_next;
    logic acc_reg, acc_next;
    logic pviol_reg, pviol_next;
    logic mg1_reg, mg1_next;
    logic mg0_reg, mg0_next;
    logic prog_reg, prog_next;
    logic [WORD_W-1:0] addr_reg, addr_next;
    logic [WORD_W-1:0] start_reg, start_next;
    logic [CNT_W-1:0] remain_reg, remain_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [1:0] word_sel_reg, word_sel_next;

    logic [7:0] cmd_code;
    logic [BLK_W-1:0] blk_sel;
    logic [WORD_W-1:0] start_addr;
    logic [WORD_W-1:0] ev_count;
    logic is_ev, is_pg, is_se, cmd_known, cmd_permit, idx_bad;
    logic [IDX_W-1:0] prog_words;
    logic [WORD_W-1:0] sector_base, chk_addr;
    logic [CNT_W-1:0] chk_words;
    logic addr_ok, fits, prot_hit;
    logic acc_err, prot_block, launch, accept;
    logic [IDX_W-1:0] word_idx;
    logic [WORD_W-1:0] expect_word;
    logic step, last_word, rd_bad;
    logic [WORD_W-1:0] addr_inc;
    logic idx_wr_ok;

    // command slots are writable only while no command runs
    assign idx_wr_ok = param_index_reg < IDX_W'(NPARAM);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NPARAM; i++) begin
                cmd_param_array[i] <= RST_PARAM;
            end
            param_index_reg <= RST_INDEX;
        end else if (cmd_complete_flag_reg) begin
            if (param_index_wr_in) begin
                param_index_reg <= param_index_val_in;
            end
            if (param_data_wr_in && idx_wr_ok) begin
                cmd_param_array[param_index_reg] <= param_data_in;
            end
        end
    end

    // slot layout of the three commands
    assign cmd_code = cmd_param_array[IDX_CMD][WORD_W-1:CMD_POS];
    assign blk_sel = cmd_param_array[IDX_CMD][BLK_W-1:0];
    assign start_addr = cmd_param_array[IDX_ADDR];
    assign ev_count = cmd_param_array[IDX_COUNT];
    assign is_ev = cmd_code == CMD_ERASE_VERIFY;
    assign is_pg = cmd_code == CMD_PROGRAM;
    assign is_se = cmd_code == CMD_ERASE_SECTOR;
    assign cmd_known = is_ev || is_pg || is_se;
    assign cmd_permit = (is_ev && cmd_allowed_in[ALLOW_EV])
        || (is_pg && cmd_allowed_in[ALLOW_PG])
        || (is_se && cmd_allowed_in[ALLOW_SE]);
    assign idx_bad = is_ev ? (param_index_reg != IDX_COUNT)
        : is_pg ? ((param_index_reg < IDX_WORD0) || (param_index_reg > IDX_WORD3))
        : (param_index_reg != IDX_ADDR);
    assign prog_words = param_index_reg - 3'h1;
    assign sector_base = start_addr & ~SECTOR_MASK;
    assign chk_addr = is_se ? sector_base : start_addr;
    assign chk_words = is_ev ? {1'b0, ev_count}
        : is_pg ? {14'h0000, prog_words} : SECTOR_WORDS;

    dfcs_range_chk #(
        .BLOCK_ID(DF_BLOCK),
        .FIRST_ADDR(DF_FIRST),
        .LAST_ADDR(DF_LAST)
    ) u_range (
        .blk_in(blk_sel),
        .addr_in(chk_addr),
        .nwords_in(chk_words),
        .prot_en_in(prot_en_in),
        .prot_lo_in(prot_lo_in),
        .prot_hi_in(prot_hi_in),
        .addr_ok_out(addr_ok),
        .fits_out(fits),
        .prot_hit_out(prot_hit)
    );

    assign acc_err = !cmd_known || !cmd_permit || idx_bad || !addr_ok
        || start_addr[0] || !fits;
    assign prot_block = (is_pg || is_se) && prot_hit;
    assign launch = cmd_complete_clear_in && cmd_complete_flag_reg && !acc_reg && !pviol_reg;
    assign accept = launch && !acc_err && !prot_block;

    assign word_idx = IDX_WORD0 + {1'b0, word_sel_reg};
    assign expect_word = prog_reg ? cmd_param_array[word_idx] : ERASED_WORD;
    assign step = arr_req_out && arr_ack_in;
    assign last_word = remain_reg == ONE_WORD;
    assign addr_inc = addr_reg + WORD_STEP;
    assign rd_bad = arr_err_in || arr_uncorr_err_in || (arr_rdata_in != expect_word);

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        cmd_complete_flag_next = cmd_complete_flag_reg;
        acc_next = acc_reg && !access_error_clear_in;
        pviol_next = pviol_reg && !protect_violation_clear_in;
        mg1_next = mg1_reg;
        mg0_next = mg0_reg;
        prog_next = prog_reg;
        addr_next = addr_reg;
        start_next = start_reg;
        remain_next = remain_reg;
        count_next = count_reg;
        word_sel_next = word_sel_reg;
        case (state_reg)
            ST_IDLE: begin
                if (launch && acc_err) begin
                    acc_next = 1'b1;
                end else if (launch && prot_block) begin
                    pviol_next = 1'b1;
                end else if (launch) begin
                    cmd_complete_flag_next = 1'b0;
                    mg1_next = 1'b0;
                    mg0_next = 1'b0;
                    prog_next = is_pg;
                    addr_next = chk_addr;
                    start_next = chk_addr;
                    remain_next = chk_words;
                    count_next = chk_words;
                    word_sel_next = 2'h0;
                    if (is_pg) begin
                        state_next = ST_PROG;
                        op_next = OP_PROG;
                    end else if (is_se) begin
                        state_next = ST_ERASE;
                        op_next = OP_ERASE;
                    end else if (ev_count == '0) begin
                        state_next = ST_DONE;
                    end else begin
                        state_next = ST_READ;
                        op_next = OP_READ;
                    end
                end
            end
            ST_PROG: begin
                if (step && last_word) begin
                    state_next = ST_READ;
                    op_next = OP_READ;
                    addr_next = start_reg;
                    remain_next = count_reg;
                    word_sel_next = 2'h0;
                end else if (step) begin
                    addr_next = addr_inc;
                    remain_next = remain_reg - ONE_WORD;
                    word_sel_next = word_sel_reg + 2'h1;
                end
            end
            ST_ERASE: begin
                if (step) begin
                    state_next = ST_READ;
                    op_next = OP_READ;
                    addr_next = start_reg;
                    remain_next = count_reg;
                end
            end
            ST_READ: begin
                if (step) begin
                    mg1_next = mg1_reg || rd_bad;
                    mg0_next = mg0_reg || arr_uncorr_err_in;
                    addr_next = addr_inc;
                    remain_next = remain_reg - ONE_WORD;
                    word_sel_next = word_sel_reg + 2'h1;
                    if (last_word) begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                cmd_complete_flag_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                cmd_complete_flag_next = 1'b1;
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            cmd_complete_flag_reg <= RST_CMD_COMPLETE_FLAG;
            acc_reg <= RST_FLAG;
            pviol_reg <= RST_FLAG;
            mg1_reg <= RST_FLAG;
            mg0_reg <= RST_FLAG;
            prog_reg <= RST_FLAG;
            addr_reg <= RST_PARAM;
            start_reg <= RST_PARAM;
            remain_reg <= '0;
            count_reg <= '0;
            word_sel_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            cmd_complete_flag_reg <= cmd_complete_flag_next;
            acc_reg <= acc_next;
            pviol_reg <= pviol_next;
            mg1_reg <= mg1_next;
            mg0_reg <= mg0_next;
            prog_reg <= prog_next;
            addr_reg <= addr_next;
            start_reg <= start_next;
            remain_reg <= remain_next;
            count_reg <= count_next;
            word_sel_reg <= word_sel_next;
        end
    end

    assign arr_req_out = (state_reg == ST_PROG) || (state_reg == ST_ERASE)
        || (state_reg == ST_READ);
    assign arr_op_out = op_reg;
    assign arr_addr_out = addr_reg;
    assign arr_wdata_out = cmd_param_array[word_idx];
    assign cmd_complete_flag_out = cmd_complete_flag_reg;
    assign access_error_flag_out = acc_reg;
    assign protect_violation_flag_out = pviol_reg;
    assign any_error_status_out = mg1_reg;
    assign uncorrectable_error_status_out = mg0_reg;
    assign param_index_out = param_index_reg;

    default clocking dfcs_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_refused;
        cmd_complete_flag_reg && (state_reg == ST_IDLE) && !arr_req_out;
    endsequence
    sequence s_busy(dfcs_state_t st, dfcs_op_t op);
        !cmd_complete_flag_reg && (state_reg == st) && arr_req_out && (arr_op_out == op);
    endsequence

    property p_ev_start;
        accept && is_ev && (ev_count != '0) |=> s_busy(ST_READ, OP_READ)
            ##0 (arr_addr_out == $past(start_addr));
    endproperty
    a_ev_start: assert property (p_ev_start) else $error("verify did not start");
    property p_done;
        state_reg == ST_DONE |=> cmd_complete_flag_reg && !arr_req_out;
    endproperty
    a_done: assert property (p_done) else $error("complete flag not set at end");
    property p_ev_index;
        launch && is_ev && (param_index_reg != IDX_COUNT) |=> acc_reg ##0 s_refused;
    endproperty
    a_ev_index: assert property (p_ev_index) else $error("verify index fault missed");
    property p_mode;
        launch && !cmd_permit |=> acc_reg;
    endproperty
    a_mode: assert property (p_mode) else $error("disallowed command not flagged");
    property p_bad_addr;
        launch && !addr_ok |=> acc_reg ##0 s_refused;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("invalid address missed");
    property p_align;
        launch && start_addr[0] |=> acc_reg;
    endproperty
    a_align: assert property (p_align) else $error("odd address not flagged");
    property p_span;
        launch && (is_ev || is_pg) && !fits |=> acc_reg;
    endproperty
    a_span: assert property (p_span) else $error("span past end not flagged");
    property p_rd_err;
        (state_reg == ST_READ) && step && arr_uncorr_err_in |=> mg1_reg && mg0_reg;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("read error not reported");
    property p_ev_no_viol;
        launch && is_ev |=> !pviol_reg;
    endproperty
    a_ev_no_viol: assert property (p_ev_no_viol) else $error("verify raised violation");
    property p_pg_count;
        accept && is_pg |=> remain_reg == CNT_W'($past(param_index_reg) - 3'h1);
    endproperty
    a_pg_count: assert property (p_pg_count) else $error("word count wrong");
    property p_pg_index;
        launch && is_pg && (param_index_reg > IDX_WORD3) |=> acc_reg ##0 s_refused;
    endproperty
    a_pg_index: assert property (p_pg_index) else $error("program index fault missed");
    property p_protect;
        launch && !acc_err && prot_block |=> pviol_reg ##0 s_refused;
    endproperty
    a_protect: assert property (p_protect) else $error("protected target touched");
    property p_verify;
        (state_reg == ST_READ) && step && (arr_rdata_in != expect_word) |=> mg1_reg;
    endproperty
    a_verify: assert property (p_verify) else $error("verify mismatch not reported");
    property p_pg_start;
        accept && is_pg |=> s_busy(ST_PROG, OP_PROG)
            ##0 (arr_wdata_out == cmd_param_array[IDX_WORD0]);
    endproperty
    a_pg_start: assert property (p_pg_start) else $error("program did not start");
    property p_se_start;
        accept && is_se |=> s_busy(ST_ERASE, OP_ERASE)
            ##0 (arr_addr_out == ($past(start_addr) & ~SECTOR_MASK));
    endproperty
    a_se_start: assert property (p_se_start) else $error("erase did not start");
    property p_se_index;
        launch && is_se && (param_index_reg != IDX_ADDR) |=> acc_reg;
    endproperty
    a_se_index: assert property (p_se_index) else $error("erase index fault missed");
    property p_acc_hold;
        launch && acc_err |=> s_refused ##1 s_refused;
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("array started on error");
endmodule

// [rtl/dfcs_pkg.sv]
// shared constants and types of the data-flash command sequencer
package dfcs_pkg;
    localparam int WORD_W = 16;
    localparam int IDX_W = 3;
    localparam int NPARAM = 6;
    localparam int BLK_W = 2;
    localparam int CNT_W = 17;
    // command code sits in the high byte of slot 0
    localparam int CMD_POS = 8;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
    localparam logic [7:0] CMD_PROGRAM = 8'h11;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
    localparam logic [IDX_W-1:0] IDX_CMD = 3'h0;
    localparam logic [IDX_W-1:0] IDX_ADDR = 3'h1;
    localparam logic [IDX_W-1:0] IDX_COUNT = 3'h2;
    localparam logic [IDX_W-1:0] IDX_WORD0 = 3'h2;
    localparam logic [IDX_W-1:0] IDX_WORD3 = 3'h5;
    // bit positions in cmd_allowed_in
    localparam int ALLOW_EV = 0;
    localparam int ALLOW_PG = 1;
    localparam int ALLOW_SE = 2;
    localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
    localparam logic [WORD_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [CNT_W-1:0] ONE_WORD = 17'h0_0001;
    localparam logic [WORD_W-1:0] RST_PARAM = 16'h0000;
    localparam logic [IDX_W-1:0] RST_INDEX = 3'h0;
    localparam logic RST_CMD_COMPLETE_FLAG = 1'b1;
    localparam logic RST_FLAG = 1'b0;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_PROG = 2'h1,
        OP_ERASE = 2'h2
    } dfcs_op_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PROG = 5'b00010,
        ST_ERASE = 5'b00100,
        ST_READ = 5'b01000,
        ST_DONE = 5'b10000
    } dfcs_state_t;
endpackage

// [rtl/dfcs_range_chk.sv]
// address range, span and protection check for a span of nwords_in words
`timescale 1ns/1ps
module dfcs_range_chk #(
    parameter logic [1:0] BLOCK_ID = 2'h1,
    parameter logic [15:0] FIRST_ADDR = 16'h0000,
    parameter logic [15:0] LAST_ADDR = 16'hFFFF
) (
    input wire logic [dfcs_pkg::BLK_W-1:0] blk_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] addr_in,
    input wire logic [dfcs_pkg::CNT_W-1:0] nwords_in,
    input wire logic prot_en_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] prot_lo_in,
    input wire logic [dfcs_pkg::WORD_W-1:0] prot_hi_in,
    output logic addr_ok_out,
    output logic fits_out,
    output logic prot_hit_out
);
    import dfcs_pkg::*;

    logic [17:0] span_end;
    logic empty_span;

    // last byte touched by the span
    assign span_end = {2'b00, addr_in} + {nwords_in, 1'b0} - 18'h0_0001;
    assign empty_span = nwords_in == '0;
    assign addr_ok_out = (blk_in == BLOCK_ID) && (addr_in >= FIRST_ADDR)
        && (addr_in <= LAST_ADDR);
    assign fits_out = empty_span || (span_end <= {2'b00, LAST_ADDR});
    assign prot_hit_out = prot_en_in && !empty_span
        && !((span_end < {2'b00, prot_lo_in}) || (addr_in > prot_hi_in));
endmodule

// [tb/dfcs_flash_model.sv]
// behavioural data-flash array answering the sequencer
`timescale 1ns/1ps
module dfcs_flash_model #(
    parameter int SECTOR_BYTES = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire dfcs_pkg::dfcs_op_t op_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic inj_err_in,
    input wire logic inj_unc_in,
    output logic ack_out,
    output logic [15:0] rdata_out,
    output logic err_out,
    output logic unc_out,
    output logic [15:0] nops_out
);
    import dfcs_pkg::*;
    logic [15:0] mem [2048];
    logic [1:0] wait_reg;
    wire [10:0] a = addr_in[11:1];
    wire [10:0] base = a & ~11'(SECTOR_BYTES / 2 - 1);
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 2048; i++) begin
                mem[i] <= ERASED_WORD;
            end
            ack_out <= 1'b0;
            rdata_out <= 16'h0000;
            err_out <= 1'b0;
            unc_out <= 1'b0;
            nops_out <= 16'h0000;
            wait_reg <= 2'h0;
        end else begin
            ack_out <= 1'b0;
            err_out <= 1'b0;
            unc_out <= 1'b0;
            // no valid data between acks
            rdata_out <= ~rdata_out;
            if (!req_in || ack_out) begin
                wait_reg <= 2'($urandom_range(3, 0));
            end else if (wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else begin
                ack_out <= 1'b1;
                err_out <= inj_err_in;
                unc_out <= inj_unc_in;
                nops_out <= nops_out + 16'h0001;
                case (op_in)
                    // flash programming only clears bits
                    OP_PROG: mem[a] <= mem[a] & wdata_in;
                    OP_ERASE: begin
                        for (int j = 0; j < SECTOR_BYTES / 2; j++) begin
                            mem[base + 11'(j)] <= ERASED_WORD;
                        end
                    end
                    default: rdata_out <= mem[a];
                endcase
            end
        end
    end
endmodule

// [tb/dfcs_sequencer_test.sv]
// self-checking bench for the data-flash command sequencer
`timescale 1ns/1ps
module dfcs_sequencer_test;
    import dfcs_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic idx_wr = 1'b0, data_wr = 1'b0, launch = 1'b0, ae_clr = 1'b0, pv_clr = 1'b0;
    logic [IDX_W-1:0] idx_val = 3'h0;
    logic [15:0] pdata = 16'h0000, plo = 16'h0100, phi = 16'h01FF;
    logic [2:0] allowed = 3'h7;
    logic prot_en = 1'b0, inj_err = 1'b0, inj_unc = 1'b0;
    logic ack, aerr, aunc, req, cc, ae, pv, anyst, unc;
    logic [15:0] rdata, aaddr, wdata, nops;
    dfcs_op_t aop;
    logic [IDX_W-1:0] idx_out;
    logic [15:0] words [4];
    logic [4:0] expq [$];
    logic [4:0] prev = 5'h10;
    int err_total = 0, comparisons = 0, cycles = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    dfcs_sequencer #(.SECTOR_BYTES(8)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .param_index_wr_in(idx_wr), .param_index_val_in(idx_val),
        .param_data_wr_in(data_wr), .param_data_in(pdata), .cmd_complete_clear_in(launch),
        .access_error_clear_in(ae_clr), .protect_violation_clear_in(pv_clr),
        .cmd_allowed_in(allowed), .prot_en_in(prot_en), .prot_lo_in(plo), .prot_hi_in(phi),
        .arr_ack_in(ack), .arr_rdata_in(rdata), .arr_err_in(aerr), .arr_uncorr_err_in(aunc),
        .arr_req_out(req), .arr_op_out(aop), .arr_addr_out(aaddr), .arr_wdata_out(wdata),
        .cmd_complete_flag_out(cc), .access_error_flag_out(ae),
        .protect_violation_flag_out(pv), .any_error_status_out(anyst),
        .uncorrectable_error_status_out(unc), .param_index_out(idx_out));
    dfcs_flash_model #(.SECTOR_BYTES(8)) FLASH (.clk_in(sys_clk_in), .rst_in(rst_in),
        .req_in(req), .op_in(aop), .addr_in(aaddr), .wdata_in(wdata), .inj_err_in(inj_err),
        .inj_unc_in(inj_unc), .ack_out(ack), .rdata_out(rdata), .err_out(aerr),
        .unc_out(aunc), .nops_out(nops));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic put(input logic [2:0] i, input logic [15:0] d);
        @(posedge sys_clk_in);
        idx_wr <= 1'b1;
        idx_val <= i;
        @(posedge sys_clk_in);
        idx_wr <= 1'b0;
        data_wr <= 1'b1;
        pdata <= d;
        @(posedge sys_clk_in);
        data_wr <= 1'b0;
    endtask
    // load slots, set final index, launch, wait for completion, clear flags
    task automatic run(input logic [15:0] s0, input logic [15:0] addr, input logic [2:0] last,
                       input logic [4:0] exp);
        logic [15:0] n0;
        put(IDX_CMD, s0);
        put(IDX_ADDR, addr);
        for (int k = 2; k <= last && k <= 5; k++) begin
            put(3'(k), words[k-2]);
        end
        @(posedge sys_clk_in);
        idx_wr <= 1'b1;
        idx_val <= last;
        @(posedge sys_clk_in);
        n0 = nops;
        idx_wr <= 1'b0;
        launch <= 1'b1;
        expq.push_back(exp);
        @(posedge sys_clk_in);
        launch <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
        for (int t = 0; t < 4000 && cc !== 1'b1; t++) begin
            @(negedge sys_clk_in);
        end
        check({15'h0, cc}, 16'h0001);
        if (exp[3] || exp[2]) check(nops, n0);
        @(posedge sys_clk_in);
        ae_clr <= 1'b1;
        pv_clr <= 1'b1;
        @(posedge sys_clk_in);
        ae_clr <= 1'b0;
        pv_clr <= 1'b0;
    endtask
    // each completion or refusal is matched with the oldest noted expectation
    always @(negedge sys_clk_in) begin
        if (!rst_in && ((cc && !prev[4]) || (ae && !prev[3]) || (pv && !prev[2]))) begin
            if (expq.size() == 0) check(16'h0001, 16'h0000);
            else check({11'h0, cc, ae, pv, anyst, unc}, {11'h0, expq.pop_front()});
        end
        prev = {cc, ae, pv, anyst, unc};
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
    logic [15:0] bs0 [11] = '{16'h1001, 16'h1001, 16'h1101, 16'h1101, 16'h1201, 16'h1201,
                              16'h1102, 16'h1001, 16'h1001, 16'h1101, 16'h1301};
    logic [15:0] badr [11] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0011,
                               16'h0010, 16'h1000, 16'h0FFE, 16'h0FFE, 16'h0010};
    logic [2:0] blst [11] = '{3'h1, 3'h3, 3'h1, 3'h6, 3'h2, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3,
                              3'h1};
    initial begin
        void'($urandom(32'h0293));
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(negedge sys_clk_in);
        check({13'h0, idx_out}, {13'h0, RST_INDEX});
        check({11'h0, cc, ae, pv, anyst, unc}, 16'h0010);
        words[0] = 16'h0004;
        run(16'h1001, 16'h0010, 3'h2, 5'h10);
        for (int k = 0; k < 4; k++) words[k] = 16'($urandom()) & 16'h7FFF;
        run(16'h1101, 16'h0010, 3'h5, 5'h10);
        for (int k = 0; k < 4; k++) check(FLASH.mem[8+k], words[k]);
        words[0] = 16'h0004;
        run(16'h1001, 16'h0010, 3'h2, 5'h12);
        run(16'h1201, 16'h0014, 3'h1, 5'h10);
        for (int k = 0; k < 4; k++) check(FLASH.mem[8+k], ERASED_WORD);
        run(16'h1001, 16'h0010, 3'h2, 5'h10);
        words[0] = 16'h0000;
        run(16'h1001, 16'h0010, 3'h2, 5'h10);
        words[0] = 16'h1234;
        run(16'h1101, 16'h0020, 3'h2, 5'h10);
        words[0] = 16'h0002;
        run(16'h1001, 16'h0020, 3'h2, 5'h12);
        words[0] = 16'h0001;
        run(16'h1001, 16'h0022, 3'h2, 5'h10);
        @(posedge sys_clk_in);
        inj_err <= 1'b1;
        run(16'h1001, 16'h0100, 3'h2, 5'h12);
        inj_unc <= 1'b1;
        run(16'h1001, 16'h0100, 3'h2, 5'h13);
        run(16'h1101, 16'h0030, 3'h2, 5'h13);
        inj_err <= 1'b0;
        inj_unc <= 1'b0;
        run(16'h1001, 16'h0100, 3'h2, 5'h10);
        prot_en <= 1'b1;
        run(16'h1101, 16'h0100, 3'h2, 5'h14);
        run(16'h1201, 16'h0104, 3'h1, 5'h14);
        run(16'h1001, 16'h0100, 3'h2, 5'h10);
        prot_en <= 1'b0;
        words[0] = 16'h0002;
        for (int i = 0; i < 11; i++) begin
            run(bs0[i], badr[i], blst[i], 5'h18);
        end
        for (int c = 0; c < 3; c++) begin
            allowed <= 3'h7 & ~(3'h1 << c);
            run({8'h10 + 8'(c), 8'h01}, 16'h0010, (c == 2) ? 3'h1 : 3'h2, 5'h18);
        end
        allowed <= 3'h7;
        repeat (4) @(posedge sys_clk_in);
        check(16'(expq.size()), 16'h0000);
        final_report();
    end
endmodule
